// File: dct_pkg.sv
// Shared constants and types for the DMA channel transfer engine
package dct_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 32;
    localparam int BLOCK_W = 16;
    localparam int VEC_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam logic [COUNT_W-1:0] COUNT_FREE_RUN = 32'h0000_0000;
    localparam logic [VEC_W-1:0] VEC_NONE = 8'h00;
    localparam logic [VEC_W-1:0] VEC_CONV_END = 8'h56;
    localparam logic [VEC_W-1:0] VEC_TIMER_LO = 8'h58;
    localparam logic [VEC_W-1:0] VEC_TIMER_HI = 8'h6E;
    localparam logic [VEC_W-1:0] VEC_SERIAL_LO = 8'h91;
    localparam logic [VEC_W-1:0] VEC_SERIAL_HI = 8'hA2;
    localparam logic [1:0] ACT_AUTO = 2'h0;
    localparam logic [1:0] ACT_MODULE = 2'h2;
    localparam logic [1:0] ACT_EXTERNAL = 2'h3;
    localparam logic [1:0] XFER_NORMAL = 2'h0;
    localparam logic [1:0] XFER_REPEAT = 2'h1;
    localparam logic [1:0] XFER_BLOCK = 2'h2;
    localparam logic [1:0] AREA_NONE = 2'h0;
    localparam logic [1:0] AREA_SRC = 2'h1;
    localparam logic [1:0] AREA_DST = 2'h2;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    localparam logic [ADDR_W-1:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 32'h0000_0002;
    localparam logic [ADDR_W-1:0] STEP_LONG = 32'h0000_0004;
    localparam logic [BLOCK_W-1:0] BLOCK_ONE = 16'h0001;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 32'h0000_0001;

    typedef struct packed {
        logic [ADDR_W-1:0] source_address_reg;
        logic [ADDR_W-1:0] destination_address_reg;
        logic [COUNT_W-1:0] total_transfer_size_reg;
        logic [BLOCK_W-1:0] block_size_reg;
        logic [VEC_W-1:0] module_request_select_reg;
    } dct_setup_t;

    typedef struct packed {
        logic [1:0] activation_select;
        logic [1:0] transfer_mode;
        logic [1:0] access_size;
        logic single_address;
        logic single_direction_select;
        logic [1:0] repeat_area_side;
        logic src_increment;
        logic dst_increment;
        logic end_strobe_enable;
        logic ack_strobe_enable;
        logic repeat_end_int_enable;
        logic end_status_int_enable;
    } dct_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic write;
        logic [1:0] size;
        logic [DATA_W-1:0] wdata;
    } dct_bus_t;
endpackage : dct_pkg

// File: dct_fifo.sv
// Parameterised valid/ready FIFO with registered read data
module dct_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_q, rd_q;
    logic [PTR_W:0] count_q;
    logic [WIDTH-1:0] data_q;
    logic valid_q;
    wire stored = count_q != '0;
    wire load = stored && (!valid_q || out_ready);
    wire push = in_valid && in_ready;

    assign in_ready = count_q != (PTR_W+1)'(DEPTH);
    assign out_valid = valid_q;
    assign out_data = data_q;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
            valid_q <= 1'b0;
            data_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (load) begin
                rd_q <= rd_q + 1'b1;
                data_q <= mem[rd_q];
            end
            count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(load);
            if (load) begin
                valid_q <= 1'b1;
            end else if (out_ready) begin
                valid_q <= 1'b0;
            end
        end
    end
endmodule : dct_fifo

// File: dct_engine.sv
// DMA channel transfer engine: address modes, transfer modes, activation
module dct_engine
    import dct_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Configuration
    input wire dct_setup_t setup,
    input wire dct_mode_t mode,
    input wire logic setup_load,
    input wire logic transfer_enable_set,
    input wire logic transfer_enable_clear,
    input wire logic end_status_clear,
    input wire logic burst_select,
    // Activation sources
    input wire logic transfer_request_input_n,
    input wire logic [VEC_W-1:0] module_irq_vector,
    input wire logic module_irq_valid,
    // System bus
    output dct_bus_t bus,
    output logic bus_valid,
    input wire logic bus_ready,
    input wire logic [DATA_W-1:0] bus_rdata,
    output logic bus_hold,
    // External device strobes
    output logic transfer_acknowledge_strobe_n,
    output logic transfer_end_strobe_n,
    // Status and interrupts
    output logic transfer_enable,
    output logic end_status_flag,
    output logic end_interrupt,
    output logic module_flag_clear,
    output logic cpu_irq_route,
    output logic [COUNT_W-1:0] count_left,
    output logic [ADDR_W-1:0] source_now,
    output logic [ADDR_W-1:0] destination_now
);
    typedef enum logic [2:0] {S_IDLE, S_READ, S_WRITE, S_SINGLE, S_NEXT} dct_state_t;

    function automatic logic [ADDR_W-1:0] step_of(input logic [1:0] size);
        case (size)
            SIZE_WORD: step_of = STEP_WORD;
            SIZE_LONG: step_of = STEP_LONG;
            default: step_of = STEP_BYTE;
        endcase
    endfunction : step_of

    function automatic logic vec_known(input logic [VEC_W-1:0] v);
        vec_known = (v == VEC_CONV_END) || (v >= VEC_TIMER_LO && v <= VEC_TIMER_HI)
            || (v >= VEC_SERIAL_LO && v <= VEC_SERIAL_HI);
    endfunction : vec_known

    dct_state_t state_q, state_d;
    logic [ADDR_W-1:0] src_q, dst_q, src_start_q, dst_start_q;
    logic [COUNT_W-1:0] count_q;
    logic [BLOCK_W-1:0] block_q, unit_q;
    logic enable_q, flag_q, irq_q, fclr_q, route_q, hold_q;
    logic ack_n_q, end_n_q, valid_q, rpt_pending_q, free_q;
    dct_bus_t bus_q;
    logic [1:0] req_sync_q;
    logic blk_end_q;
    logic [DATA_W-1:0] fifo_out;
    logic fifo_in_ready, fifo_out_valid, fifo_take;

    // Request input through two flip-flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            req_sync_q <= 2'b11;
        end else begin
            req_sync_q <= {req_sync_q[0], transfer_request_input_n};
        end
    end

    // Activation source decode
    wire ext_req = !req_sync_q[1];
    wire vec_hit = module_irq_valid && setup.module_request_select_reg != VEC_NONE
        && module_irq_vector == setup.module_request_select_reg;
    wire vec_ok = vec_known(setup.module_request_select_reg);
    wire mod_req = vec_hit && vec_ok;
    wire auto_go = mode.activation_select == ACT_AUTO;
    wire request = enable_q && (auto_go || (mode.activation_select == ACT_MODULE && mod_req)
        || (mode.activation_select == ACT_EXTERNAL && ext_req));
    wire is_block = mode.transfer_mode == XFER_BLOCK;
    wire is_repeat = mode.transfer_mode == XFER_REPEAT;
    wire last_count = !free_q && count_q == COUNT_ONE;
    wire last_unit = is_block ? (unit_q == BLOCK_ONE) : 1'b1;
    wire last_rpt = block_q == BLOCK_ONE;
    wire stop_rpt = rpt_pending_q && mode.repeat_end_int_enable;
    wire start = state_q == S_IDLE && request && !stop_rpt;
    wire unit_done = (state_q == S_WRITE || state_q == S_SINGLE) && bus_ready;
    wire end_now = last_count && (is_block ? last_unit : 1'b1);
    wire [ADDR_W-1:0] step = step_of(mode.access_size);
    wire reload = is_block ? last_unit : (is_repeat && last_rpt);
    wire reload_src = reload && mode.repeat_area_side == AREA_SRC;
    wire reload_dst = reload && mode.repeat_area_side == AREA_DST;
    wire dir_in = mode.single_direction_select;
    assign fifo_take = state_q == S_WRITE && bus_ready;

    // Read data held between the two dual-address cycles
    dct_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(state_q == S_READ && bus_ready),
        .in_ready(fifo_in_ready),
        .in_data(bus_rdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_take),
        .out_data(fifo_out)
    );

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (start) begin
                    state_d = mode.single_address ? S_SINGLE : S_READ;
                end
            end
            S_READ: begin
                if (bus_ready && fifo_in_ready) begin
                    state_d = S_WRITE;
                end
            end
            S_WRITE: begin
                if (bus_ready) begin
                    state_d = S_NEXT;
                end
            end
            S_SINGLE: begin
                if (bus_ready) begin
                    state_d = S_NEXT;
                end
            end
            S_NEXT: begin
                if (!enable_q || (!is_block && !(auto_go && burst_select)) || (is_block && blk_end_q)) begin
                    state_d = S_IDLE;
                end else begin
                    state_d = mode.single_address ? S_SINGLE : S_READ;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Addresses and counters
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            src_q <= '0;
            dst_q <= '0;
            src_start_q <= '0;
            dst_start_q <= '0;
            count_q <= '0;
            block_q <= '0;
            unit_q <= '0;
            free_q <= 1'b0;
            rpt_pending_q <= 1'b0;
            blk_end_q <= 1'b0;
        end else if (setup_load) begin
            src_q <= setup.source_address_reg;
            dst_q <= setup.destination_address_reg;
            src_start_q <= setup.source_address_reg;
            dst_start_q <= setup.destination_address_reg;
            count_q <= setup.total_transfer_size_reg;
            free_q <= setup.total_transfer_size_reg == COUNT_FREE_RUN;
            block_q <= setup.block_size_reg;
            unit_q <= setup.block_size_reg;
            rpt_pending_q <= 1'b0;
            blk_end_q <= 1'b0;
        end else begin
            if (start) begin
                rpt_pending_q <= 1'b0;
            end
            if (unit_done) begin
                if (!free_q) begin
                    count_q <= count_q - COUNT_ONE;
                end
                src_q <= reload_src ? src_start_q : (mode.src_increment ? src_q + step : src_q);
                dst_q <= reload_dst ? dst_start_q : (mode.dst_increment ? dst_q + step : dst_q);
                unit_q <= last_unit ? setup.block_size_reg : unit_q - BLOCK_ONE;
                blk_end_q <= last_unit;
                if (is_repeat) begin
                    block_q <= last_rpt ? setup.block_size_reg : block_q - BLOCK_ONE;
                    rpt_pending_q <= last_rpt;
                end else if (is_block && last_unit) begin
                    rpt_pending_q <= 1'b1;
                end
            end
        end
    end

    // Enable, end flag and interrupt routing
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            enable_q <= 1'b0;
            flag_q <= 1'b0;
            irq_q <= 1'b0;
            fclr_q <= 1'b0;
            route_q <= 1'b0;
        end else begin
            if (state_q == S_IDLE && request && stop_rpt) begin
                enable_q <= 1'b0;
            end else if (unit_done && end_now) begin
                enable_q <= 1'b0;
            end else if (transfer_enable_clear) begin
                enable_q <= 1'b0;
            end else if (transfer_enable_set) begin
                enable_q <= 1'b1;
            end
            if (state_q == S_IDLE && request && stop_rpt) begin
                flag_q <= 1'b1;
            end else if (end_status_clear) begin
                flag_q <= 1'b0;
            end
            irq_q <= (flag_q || (state_q == S_IDLE && request && stop_rpt)) && mode.end_status_int_enable;
            fclr_q <= start && mode.activation_select == ACT_MODULE;
            route_q <= vec_hit && !enable_q;
        end
    end

    // Bus and strobes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bus_q <= '0;
            valid_q <= 1'b0;
            hold_q <= 1'b0;
            ack_n_q <= 1'b1;
            end_n_q <= 1'b1;
        end else begin
            valid_q <= state_d == S_READ || (state_d == S_WRITE && fifo_out_valid) || state_d == S_SINGLE;
            hold_q <= state_d != S_IDLE;
            case (state_d)
                S_READ: bus_q <= '{address: src_q, write: 1'b0, size: mode.access_size, wdata: '0};
                S_WRITE: bus_q <= '{address: dst_q, write: 1'b1, size: mode.access_size, wdata: fifo_out};
                S_SINGLE: bus_q <= '{address: dir_in ? dst_q : src_q, write: dir_in,
                    size: mode.access_size, wdata: '0};
                default: bus_q <= bus_q;
            endcase
            ack_n_q <= !(state_d == S_SINGLE && mode.single_address && mode.ack_strobe_enable);
            end_n_q <= !(mode.end_strobe_enable && end_now
                && (state_d == S_READ || state_d == S_WRITE || state_d == S_SINGLE));
        end
    end

    // Block requests assume level detection
    assign bus = bus_q;
    assign bus_valid = valid_q;
    assign bus_hold = hold_q;
    assign transfer_acknowledge_strobe_n = ack_n_q;
    assign transfer_end_strobe_n = end_n_q;
    assign transfer_enable = enable_q;
    assign end_status_flag = flag_q;
    assign end_interrupt = irq_q;
    assign module_flag_clear = fclr_q;
    assign cpu_irq_route = route_q;
    assign count_left = count_q;
    assign source_now = src_q;
    assign destination_now = dst_q;
endmodule : dct_engine

// File: dct_engine_checker.sv
// Port assertions for the DMA channel transfer engine
module dct_engine_checker
    import dct_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Configuration
    input wire dct_setup_t setup,
    input wire dct_mode_t mode,
    // Bus
    input wire dct_bus_t bus,
    input wire logic bus_valid,
    input wire logic bus_ready,
    input wire logic bus_hold,
    // Strobes and status
    input wire logic transfer_acknowledge_strobe_n,
    input wire logic transfer_end_strobe_n,
    input wire logic transfer_enable,
    input wire logic end_status_flag,
    input wire logic module_flag_clear
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_bus_request_stands: assert property (bus_valid && !bus_ready |=> bus_valid && $stable(bus))
        else $error("bus request changed before ready");
    a_dual_read_write: assert property (bus_valid && bus_ready && !bus.write && !mode.single_address
        |=> bus_hold ##[0:8] (bus_valid && bus.write)) else $error("dual read not followed by write");
    a_dual_no_ack: assert property (bus_valid && !mode.single_address |-> transfer_acknowledge_strobe_n)
        else $error("acknowledge driven in dual mode");
    a_end_gated: assert property (bus_valid && !mode.end_strobe_enable |-> transfer_end_strobe_n)
        else $error("end strobe driven while disabled");
    a_ack_gated: assert property (bus_valid && !mode.ack_strobe_enable |-> transfer_acknowledge_strobe_n)
        else $error("acknowledge driven while disabled");
    a_single_ack_low: assert property
        (bus_valid && mode.single_address && mode.ack_strobe_enable |-> !transfer_acknowledge_strobe_n)
        else $error("acknowledge missing in single mode");
    a_single_direction: assert property
        (bus_valid && mode.single_address |-> bus.write == mode.single_direction_select)
        else $error("single mode direction wrong");
    a_start_needs_enable: assert property
        (bus_valid && !$past(bus_valid) && !bus.write |-> $past(transfer_enable))
        else $error("transfer started while disabled");
    a_vector_none_quiet: assert property
        (mode.activation_select == ACT_MODULE && setup.module_request_select_reg == VEC_NONE |-> !module_flag_clear)
        else $error("module source cleared with no vector");
    a_stop_with_flag: assert property ($rose(end_status_flag) |-> ##[0:1] !transfer_enable)
        else $error("end flag set while channel enabled");
endmodule : dct_engine_checker

bind dct_engine dct_engine_checker checker_i (.clock, .reset_n, .setup, .mode, .bus, .bus_valid, .bus_ready, .bus_hold,
    .transfer_acknowledge_strobe_n, .transfer_end_strobe_n, .transfer_enable, .end_status_flag, .module_flag_clear);

// File: dct_bus_model.sv
// Memory and bus responder on the far side of the engine
module dct_bus_model
    import dct_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Request
    input wire dct_bus_t bus,
    input wire logic bus_valid,
    input wire logic slow,
    // Answer
    output logic bus_ready,
    output logic [DATA_W-1:0] bus_rdata
);
    logic [7:0] mem [256];
    logic [1:0] wait_q;
    logic flip_q;
    assign bus_rdata = bus_ready ? {24'h00_0000, mem[bus.address[7:0]]} : {DATA_W{flip_q}};
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bus_ready <= 1'b0;
            wait_q <= 2'h0;
            flip_q <= 1'b0;
        end else begin
            flip_q <= !flip_q;
            bus_ready <= 1'b0;
            wait_q <= 2'h0;
            if (bus_valid && !bus_ready) begin
                wait_q <= wait_q + 2'h1;
                if (!slow || wait_q == 2'h3) begin
                    bus_ready <= 1'b1;
                    if (bus.write) begin
                        mem[bus.address[7:0]] <= bus.wdata[7:0];
                    end
                end
            end
        end
    end
endmodule : dct_bus_model

// File: dct_engine_tb.sv
// Self-checking bench for the DMA channel transfer engine
module dct_engine_tb
    import dct_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, reset_n = 1'b0, setup_load = 1'b0, transfer_enable_set = 1'b0, transfer_enable_clear = 1'b0;
    logic end_status_clear = 1'b0, burst_select = 1'b0, transfer_request_input_n = 1'b1, slow = 1'b0;
    logic module_irq_valid = 1'b0;
    logic [VEC_W-1:0] module_irq_vector = 8'h00;
    dct_setup_t setup = '0;
    dct_mode_t mode = '0;
    dct_bus_t bus;
    logic bus_valid, bus_ready, bus_hold, transfer_acknowledge_strobe_n, transfer_end_strobe_n, transfer_enable;
    logic end_status_flag, end_interrupt, module_flag_clear, cpu_irq_route;
    logic [DATA_W-1:0] bus_rdata;
    int mismatches = 0, tests_run = 0, n_rd = 0, n_wr = 0, n_end = 0, n_ack = 0, n_clr = 0;
    logic [7:0] addr_q [$];

    always #10 clock = ~clock;

    dct_engine dut (.clock, .reset_n, .setup, .mode, .setup_load, .transfer_enable_set, .transfer_enable_clear,
        .end_status_clear, .burst_select, .transfer_request_input_n, .module_irq_vector, .module_irq_valid, .bus,
        .bus_valid, .bus_ready, .bus_rdata, .bus_hold, .transfer_acknowledge_strobe_n, .transfer_end_strobe_n,
        .transfer_enable, .end_status_flag, .end_interrupt, .module_flag_clear, .cpu_irq_route, .count_left(),
        .source_now(), .destination_now());
    dct_bus_model mdl (.clock, .reset_n, .bus, .bus_valid, .slow, .bus_ready, .bus_rdata);

    // Bus cycle monitor
    always @(posedge clock) begin
        if (bus_valid === 1'b1 && bus_ready === 1'b1) begin
            n_wr += int'(bus.write);
            n_rd += int'(!bus.write);
            n_end += int'(!transfer_end_strobe_n);
            n_ack += int'(!transfer_acknowledge_strobe_n);
            addr_q.push_back(bus.address[7:0]);
        end
        n_clr += int'(module_flag_clear === 1'b1);
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic dct_mode_t mk(input logic [1:0] act, xm, input logic sgl, dir, input logic [1:0] area,
        input logic en, rpt);
        mk = '{act, xm, SIZE_BYTE, sgl, dir, area, 1'b1, 1'b1, en, en, rpt, 1'b1};
    endfunction : mk

    task automatic set_en(input logic on);
        transfer_enable_set <= on;
        transfer_enable_clear <= !on;
        @(posedge clock);
        transfer_enable_set <= 1'b0;
        transfer_enable_clear <= 1'b0;
    endtask : set_en

    task automatic start(input dct_mode_t m, input logic [31:0] cnt, input logic [15:0] blk, input logic [7:0] vec);
        n_rd = 0;
        n_wr = 0;
        n_end = 0;
        n_ack = 0;
        n_clr = 0;
        addr_q.delete();
        mode <= m;
        setup <= '{32'h0000_0010, 32'h0000_0080, cnt, blk, vec};
        setup_load <= 1'b1;
        @(posedge clock);
        setup_load <= 1'b0;
        set_en(1'b1);
    endtask : start

    task automatic wait_off();
        repeat (2) @(posedge clock);
        for (int i = 0; i < 400 && transfer_enable !== 1'b0; i++) @(posedge clock);
        repeat (4) @(posedge clock);
    endtask : wait_off

    task automatic s_dual();
        burst_select <= 1'b1;
        start(mk(ACT_AUTO, XFER_NORMAL, 1'b0, 1'b0, AREA_NONE, 1'b1, 1'b0), 32'h0000_0003, 16'h0005, VEC_NONE);
        wait_off();
        chk(n_rd, 3);
        chk(n_end, 2);
        chk(n_ack, 0);
        for (int i = 0; i < 6; i++) chk(addr_q[i], i[0] ? 8'h80 + i / 2 : 8'h10 + i / 2);
        for (int i = 0; i < 3; i++) chk(mdl.mem[8'h80 + i], 8'h10 + i ^ 8'h5A);
        chk(transfer_enable, 0);
        burst_select <= 1'b0;
    endtask : s_dual

    task automatic s_single(input logic dir, en);
        slow <= 1'b1;
        start(mk(ACT_AUTO, XFER_NORMAL, 1'b1, dir, AREA_NONE, en, 1'b0), 32'h0000_0002, BLOCK_ONE, VEC_NONE);
        wait_off();
        chk(n_rd + n_wr, 2);
        chk(n_wr, dir ? 2 : 0);
        chk(addr_q[1], dir ? 8'h81 : 8'h11);
        chk(n_ack, en ? 2 : 0);
        chk(n_end, en ? 1 : 0);
        slow <= 1'b0;
    endtask : s_single

    task automatic s_free();
        start(mk(ACT_AUTO, XFER_REPEAT, 1'b0, 1'b0, AREA_SRC, 1'b1, 1'b0), COUNT_FREE_RUN, 16'h0002, VEC_NONE);
        repeat (60) @(posedge clock);
        set_en(1'b0);
        wait_off();
        chk(n_rd > 4, 1);
        chk(addr_q[4], 8'h10);
        chk(addr_q[5], 8'h82);
    endtask : s_free

    task automatic s_stop();
        start(mk(ACT_AUTO, XFER_REPEAT, 1'b0, 1'b0, AREA_NONE, 1'b1, 1'b1), COUNT_FREE_RUN, 16'h0002, VEC_NONE);
        wait_off();
        chk(n_wr, 2);
        chk(end_status_flag, 1);
        chk(end_interrupt, 1);
        end_status_clear <= 1'b1;
        @(posedge clock);
        end_status_clear <= 1'b0;
        repeat (3) @(posedge clock);
        chk(end_status_flag, 0);
    endtask : s_stop

    task automatic s_block();
        start(mk(ACT_EXTERNAL, XFER_BLOCK, 1'b0, 1'b0, AREA_DST, 1'b1, 1'b0), 32'h0000_0006, 16'h0003, VEC_NONE);
        for (int i = 0; i < 2; i++) begin
            transfer_request_input_n <= 1'b0;
            for (int k = 0; k < 50 && bus_valid !== 1'b1; k++) @(posedge clock);
            transfer_request_input_n <= 1'b1;
            repeat (60) @(posedge clock);
            chk(n_wr, 3 * i + 3);
        end
        chk(transfer_enable, 0);
        chk(addr_q[7], 8'h80);
        chk(addr_q[6], 8'h13);
    endtask : s_block

    task automatic s_module();
        logic [7:0] vt [4] = '{VEC_NONE, VEC_CONV_END, VEC_TIMER_LO, VEC_SERIAL_HI};
        for (int i = 0; i < 4; i++) begin
            start(mk(ACT_MODULE, XFER_NORMAL, 1'b0, 1'b0, AREA_NONE, 1'b1, 1'b0), COUNT_ONE, BLOCK_ONE, vt[i]);
            set_en(1'b0);
            module_irq_vector <= vt[i];
            module_irq_valid <= 1'b1;
            repeat (4) @(posedge clock);
            chk(cpu_irq_route, i != 0);
            module_irq_valid <= 1'b0;
            set_en(1'b1);
            module_irq_vector <= ~vt[i];
            module_irq_valid <= 1'b1;
            repeat (6) @(posedge clock);
            module_irq_vector <= vt[i];
            for (int k = 0; k < 20 && module_flag_clear !== 1'b1; k++) @(posedge clock);
            module_irq_valid <= 1'b0;
            repeat (12) @(posedge clock);
            chk(n_rd, i != 0);
            chk(n_clr, i != 0);
            chk(transfer_enable, i == 0);
        end
    endtask : s_module

    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        s_dual();
        s_single(1'b0, 1'b1);
        s_single(1'b1, 1'b0);
        s_free();
        s_stop();
        s_block();
        s_module();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        complete_run();
    end
endmodule : dct_engine_tb
